// ==== core/terminal_router_pkg.sv ====
// Constants shared by the multifunction terminal router
// How it works
// - Terminal 6 is undriven for code 0000, carries clock-run for 0001, and carries IRQ2 to IRQ15 for 0010 to 1111.
// - Terminal 5 carries input 4, output 4, IRQ3, card debug receive, IRQ5, audio PWM, IRQ9, link LED, LED A1, socket LED, event output or IRQ15 by code.
// - Terminal 4 carries input 3, output 3, bus lock, IRQ3, IRQ4, card debug transmit, audio PWM, IRQ9, INTD, ring indicate, socket LED, event output or IRQ15 by code.
// - Terminal 3 is undriven for code 0000, carries the serialized interrupt for 0001, and carries IRQ2 to IRQ15 for 0010 to 1111.
// - Terminal 2 carries input 2, output 2, IRQ3, IRQ4, IRQ5, audio PWM, IRQ10, INTC, ring indicate, test_multiplexer_output, event output or IRQ7 by code.
// - Terminal 1 carries input 1, output 1, INTB, link LED or IRQ5 by code, and every other code is treated as reserved.
// - Terminal 0 carries input 0, output 0, INTA, IRQ4, IRQ5, audio PWM, IRQ9, IRQ10, IRQ11, LED A1, event output or IRQ15 by code.
// - The top four bits of the routing register read as zero and ignore writes.
// - Only the global reset returns the routing fields to their reset value 0000_1000; the system reset leaves them alone.
// - A default routing word can be loaded from the serial EEPROM interface.
// - A terminal set to a general-purpose output drives the matching output register bit.
// - A terminal set to a general-purpose input shows its level in the matching input register bit.
package terminal_router_pkg;
  localparam int TERM_COUNT = 7;
  localparam int SEL_W = 4;
  localparam int GP_W = 5;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_ROUTING = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_GP_OUT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_GP_IN = 4'h8;
  localparam logic [31:0] ROUTING_RESET = 32'h0000_1000;
  localparam logic [31:0] ROUTING_WMASK = 32'h0FFF_FFFF;
  localparam logic [GP_W-1:0] GP_OUT_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Positions in the packed vector of single internal sources
  localparam int SRC_CLKRUN = 0;
  localparam int SRC_SERIAL_IRQ = 1;
  localparam int SRC_LOCK = 2;
  localparam int SRC_INTA = 3;
  localparam int SRC_INTB = 4;
  localparam int SRC_INTC = 5;
  localparam int SRC_INTD = 6;
  localparam int SRC_PWM = 7;
  localparam int SRC_SC_TX = 8;
  localparam int SRC_LED_A1 = 9;
  localparam int SRC_SOCKET_LED = 10;
  localparam int SRC_LED_LINK = 11;
  localparam int SRC_EVENT = 12;
  localparam int SRC_RI = 13;
  localparam int SRC_TMUX = 14;
  localparam int SRC_W = 15;
  // Terminal that carries the card debug receive line
  localparam int SC_RX_TERM = 5;
  localparam logic [SEL_W-1:0] SC_RX_CODE = 4'h4;
endpackage

// ==== core/level_sync.sv ====
// Two-stage synchroniser for levels arriving from pins
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge ref_clk) begin
    meta_ff <= d;
    q <= meta_ff;
  end
endmodule

// ==== core/multifunction_terminal_router.sv ====
// Multifunction terminal router with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
module multifunction_terminal_router
  import terminal_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic global_reset_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Default routing from serial EEPROM loader
  input wire logic eeprom_load_valid,
  input wire logic [31:0] eeprom_load_data,
  // Internal sources
  input wire logic [15:0] irq_lines,
  input wire logic clock_run,
  input wire logic serialized_interrupt,
  input wire logic pci_lock,
  input wire logic [3:0] pci_int,
  input wire logic card_audio_pwm,
  input wire logic smartcard_debug_transmit,
  input wire logic activity_led_a1,
  input wire logic socket_led,
  input wire logic link_activity_led,
  input wire logic general_event_output,
  input wire logic ring_indicate_output,
  input wire logic test_multiplexer_output,
  output logic smartcard_debug_receive,
  // Shared terminals
  input wire logic [TERM_COUNT-1:0] term_in,
  output logic [TERM_COUNT-1:0] term_out,
  output logic [TERM_COUNT-1:0] term_oe
);
  logic [31:0] routing_ff;
  logic [GP_W-1:0] gp_output_ff;
  logic [GP_W-1:0] gp_input_ff;
  logic [TERM_COUNT-1:0] term_sync;
  logic glob_rst_n_sync;
  logic global_reset;
  logic [SRC_W-1:0] src;
  logic [TERM_COUNT-1:0] nxt_term_out;
  logic [TERM_COUNT-1:0] nxt_term_oe;
  logic [TERM_COUNT-1:0] term_is_gpi;
  logic [GP_W-1:0] nxt_gp_input;

  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;
  logic wr_hit;
  logic [31:0] bytemask;
  logic ar_take;
  logic nxt_rvalid;

  // Pin levels enter through two flip-flops
  level_sync #(.WIDTH(TERM_COUNT + 1)) u_sync (
    .ref_clk(ref_clk),
    .d({global_reset_n, term_in}),
    .q({glob_rst_n_sync, term_sync})
  );

  assign global_reset = ~glob_rst_n_sync;

  assign src[SRC_CLKRUN] = clock_run;
  assign src[SRC_SERIAL_IRQ] = serialized_interrupt;
  assign src[SRC_LOCK] = pci_lock;
  assign src[SRC_INTA] = pci_int[0];
  assign src[SRC_INTB] = pci_int[1];
  assign src[SRC_INTC] = pci_int[2];
  assign src[SRC_INTD] = pci_int[3];
  assign src[SRC_PWM] = card_audio_pwm;
  assign src[SRC_SC_TX] = smartcard_debug_transmit;
  assign src[SRC_LED_A1] = activity_led_a1;
  assign src[SRC_SOCKET_LED] = socket_led;
  assign src[SRC_LED_LINK] = link_activity_led;
  assign src[SRC_EVENT] = general_event_output;
  assign src[SRC_RI] = ring_indicate_output;
  assign src[SRC_TMUX] = test_multiplexer_output;

  // Returns {drive enable, drive value, is general-purpose input}
  function automatic logic [2:0] route_term(
    input int idx,
    input logic [SEL_W-1:0] sel,
    input logic [15:0] irq,
    input logic [SRC_W-1:0] s,
    input logic [GP_W-1:0] gpo
  );
    logic oe;
    logic val;
    logic gpi;
    oe = 1'b1;
    val = 1'b0;
    gpi = 1'b0;
    case (idx)
      6: begin
        if (sel == 4'h0) oe = 1'b0;
        else if (sel == 4'h1) val = s[SRC_CLKRUN];
        else val = irq[sel];
      end
      5: begin
        case (sel)
          4'h0: begin
            oe = 1'b0;
            gpi = 1'b1;
          end
          4'h1: val = gpo[4];
          4'h3: val = irq[3];
          4'h4: oe = 1'b0;
          4'h5: val = irq[5];
          4'h8: val = s[SRC_PWM];
          4'h9: val = irq[9];
          4'hB: val = s[SRC_LED_LINK];
          4'hC: val = s[SRC_LED_A1];
          4'hD: val = s[SRC_SOCKET_LED];
          4'hE: val = s[SRC_EVENT];
          4'hF: val = irq[15];
          default: oe = 1'b0;
        endcase
      end
      4: begin
        case (sel)
          4'h0: begin
            oe = 1'b0;
            gpi = 1'b1;
          end
          4'h1: val = gpo[3];
          4'h2: val = s[SRC_LOCK];
          4'h3: val = irq[3];
          4'h4: val = irq[4];
          4'h5: val = s[SRC_SC_TX];
          4'h8: val = s[SRC_PWM];
          4'h9: val = irq[9];
          4'hA: val = s[SRC_INTD];
          4'hC: val = s[SRC_RI];
          4'hD: val = s[SRC_SOCKET_LED];
          4'hE: val = s[SRC_EVENT];
          4'hF: val = irq[15];
          default: oe = 1'b0;
        endcase
      end
      3: begin
        if (sel == 4'h0) oe = 1'b0;
        else if (sel == 4'h1) val = s[SRC_SERIAL_IRQ];
        else val = irq[sel];
      end
      2: begin
        case (sel)
          4'h0: begin
            oe = 1'b0;
            gpi = 1'b1;
          end
          4'h1: val = gpo[2];
          4'h3: val = irq[3];
          4'h4: val = irq[4];
          4'h5: val = irq[5];
          4'h8: val = s[SRC_PWM];
          4'hA: val = irq[10];
          4'hB: val = s[SRC_INTC];
          4'hC: val = s[SRC_RI];
          4'hD: val = s[SRC_TMUX];
          4'hE: val = s[SRC_EVENT];
          4'hF: val = irq[7];
          default: oe = 1'b0;
        endcase
      end
      1: begin
        case (sel)
          4'h0: begin
            oe = 1'b0;
            gpi = 1'b1;
          end
          4'h1: val = gpo[1];
          4'h2: val = s[SRC_INTB];
          4'h4: val = s[SRC_LED_LINK];
          4'h5: val = irq[5];
          default: oe = 1'b0;
        endcase
      end
      default: begin
        case (sel)
          4'h0: begin
            oe = 1'b0;
            gpi = 1'b1;
          end
          4'h1: val = gpo[0];
          4'h2: val = s[SRC_INTA];
          4'h4: val = irq[4];
          4'h5: val = irq[5];
          4'h8: val = s[SRC_PWM];
          4'h9: val = irq[9];
          4'hA: val = irq[10];
          4'hB: val = irq[11];
          4'hC: val = s[SRC_LED_A1];
          4'hE: val = s[SRC_EVENT];
          4'hF: val = irq[15];
          default: oe = 1'b0;
        endcase
      end
    endcase
    return {oe, val, gpi};
  endfunction

  // One routing decode per terminal
  genvar t;
  generate
    for (t = 0; t < TERM_COUNT; t++) begin : g_term
      logic [2:0] r;
      assign r = route_term(t, routing_ff[t*SEL_W +: SEL_W], irq_lines, src, gp_output_ff);
      assign nxt_term_oe[t] = r[2];
      assign nxt_term_out[t] = r[1] & r[2];
      assign term_is_gpi[t] = r[0];
    end
  endgenerate

  // Input bits follow their terminal only while it is a general-purpose input
  assign nxt_gp_input[0] = term_is_gpi[0] & term_sync[0];
  assign nxt_gp_input[1] = term_is_gpi[1] & term_sync[1];
  assign nxt_gp_input[2] = term_is_gpi[2] & term_sync[2];
  assign nxt_gp_input[3] = term_is_gpi[4] & term_sync[4];
  assign nxt_gp_input[4] = term_is_gpi[5] & term_sync[5];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      term_out <= '0;
      term_oe <= '0;
      gp_input_ff <= '0;
      smartcard_debug_receive <= 1'b0;
    end else begin
      term_out <= nxt_term_out;
      term_oe <= nxt_term_oe;
      gp_input_ff <= nxt_gp_input;
      smartcard_debug_receive <= (routing_ff[SC_RX_TERM*SEL_W +: SEL_W] == SC_RX_CODE)
        & term_sync[SC_RX_TERM];
    end
  end

  // Write channel handshake
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign nxt_aw_held = do_write ? 1'b0 : (aw_held_ff | aw_take);
  assign nxt_w_held = do_write ? 1'b0 : (w_held_ff | w_take);
  assign nxt_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_hit = (awaddr_ff == OFS_ROUTING) | (awaddr_ff == OFS_GP_OUT);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      s_axi_awready <= ~nxt_aw_held & ~nxt_bvalid;
      s_axi_wready <= ~nxt_w_held & ~nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (do_write) s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (aw_take) awaddr_ff <= s_axi_awaddr;
    if (w_take) begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  for (t = 0; t < 4; t++) begin : g_lane
    assign bytemask[t*8 +: 8] = {8{wstrb_ff[t]}};
  end

  // Routing word: loaded with ROUTING_RESET only by global reset, never by sys_rst
  always_ff @(posedge ref_clk) begin
    if (global_reset) routing_ff <= ROUTING_RESET;
    else if (eeprom_load_valid) routing_ff <= eeprom_load_data & ROUTING_WMASK;
    else if (do_write && awaddr_ff == OFS_ROUTING)
      routing_ff <= ((routing_ff & ~bytemask) | (wdata_ff & bytemask)) & ROUTING_WMASK;
  end

  always_ff @(posedge ref_clk) begin
    if (global_reset) gp_output_ff <= GP_OUT_RESET;
    else if (do_write && awaddr_ff == OFS_GP_OUT && wstrb_ff[0])
      gp_output_ff <= wdata_ff[GP_W-1:0];
  end

  // Read channel
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (ar_take) begin
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_ROUTING: s_axi_rdata <= routing_ff & ROUTING_WMASK;
          OFS_GP_OUT: s_axi_rdata <= {{(32-GP_W){1'b0}}, gp_output_ff};
          OFS_GP_IN: s_axi_rdata <= {{(32-GP_W){1'b0}}, gp_input_ff};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

// ==== testbench/terminal_router_chk.sv ====
// Bus and terminal assertions for the terminal router
`timescale 1ns/1ns
module terminal_router_chk
  import terminal_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic smartcard_debug_receive,
  input wire logic [TERM_COUNT-1:0] term_out,
  input wire logic [TERM_COUNT-1:0] term_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [ADDR_W-1:0] ra_ff;
  // Address of the read in flight
  always_ff @(posedge ref_clk) begin
    if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
  end
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response changed early");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_w_to_b: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer not on time");
  a_top_nibble_zero: assert property (s_axi_rvalid && ra_ff == OFS_ROUTING |->
    s_axi_rdata[31:28] == 4'h0) else $error("routing top bits not zero");
  a_undriven_low: assert property ((term_out & ~term_oe) == 7'h00)
    else $error("undriven terminal shows a value");
  a_rx_input: assert property (smartcard_debug_receive |-> !term_oe[SC_RX_TERM])
    else $error("receive terminal is driven");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !s_axi_bvalid && !s_axi_rvalid && term_oe == 7'h00) else $error("reset left outputs up");
endmodule
bind multifunction_terminal_router terminal_router_chk i_chk (.ref_clk, .sys_rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .smartcard_debug_receive, .term_out, .term_oe);

// ==== testbench/terminal_board_model.sv ====
// Board side of the shared terminals
`timescale 1ns/1ns
module terminal_board_model
  import terminal_router_pkg::*;
(
  input wire logic [TERM_COUNT-1:0] term_out,
  input wire logic [TERM_COUNT-1:0] term_oe,
  input wire logic [TERM_COUNT-1:0] ext_level,
  output logic [TERM_COUNT-1:0] term_in
);
  // Board drives only where the router lets go
  always_comb term_in = (term_out & term_oe) | (ext_level & ~term_oe);
endmodule

// ==== testbench/multifunction_terminal_router_tb.sv ====
// Self-checking bench for the terminal router
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch %0t: got %h exp %h", $time, a, b); end end
module multifunction_terminal_router_tb;
  import terminal_router_pkg::*;
  logic ref_clk = 0, sys_rst = 1, global_reset_n = 0, eeprom_load_valid = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, smartcard_debug_receive;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, eeprom_load_data = 0, s = 0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [6:0] term_in, term_out, term_oe, ext_level = 0;
  logic [27:0] rt;
  logic [7:0] e;
  logic [4:0] gpo, gpi;
  int n_mismatch = 0, comparisons = 0, waitn = 0, seed = 32'haa1d69ed;
  // Source index per terminal and code: 2k output k, 3k input k, FF none, EE unchecked
  localparam logic [127:0] TBL [7] = '{128'h0F1CFF190B0A0917EEFF0504EE132030,
    128'hFFFFFFFFFFFFFFFFFFFF051BFF142131, 128'h071C1E1D150AFF17FFFF050403FF2232,
    128'h0F0E0D0C0B0A090807060504030211FF, 128'h0F1C1A1DFF160917FFFF180403122333,
    128'h0F1C1A191BFF0917FFFF053F03FF2434, 128'h0F0E0D0C0B0A090807060504030210FF};
  multifunction_terminal_router i_dut (.ref_clk, .sys_rst, .global_reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eeprom_load_valid,
    .eeprom_load_data, .irq_lines(s[15:0]), .clock_run(s[16]), .serialized_interrupt(s[17]),
    .pci_lock(s[18]), .pci_int(s[22:19]), .card_audio_pwm(s[23]),
    .smartcard_debug_transmit(s[24]), .activity_led_a1(s[25]), .socket_led(s[26]),
    .link_activity_led(s[27]), .general_event_output(s[28]), .ring_indicate_output(s[29]),
    .test_multiplexer_output(s[30]), .smartcard_debug_receive, .term_in, .term_out, .term_oe);
  terminal_board_model i_board (.term_out, .term_oe, .ext_level, .term_in);
  initial forever #20 ref_clk = ~ref_clk;
  task give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick;
    @(posedge ref_clk);
    waitn++;
    if (waitn > 100) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    waitn = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w) begin
      tick;
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1) tick;
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge ref_clk);
  endtask
  task rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    waitn = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do tick; while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do tick; while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge ref_clk);
  endtask
  // Expected {oe, out} for one terminal
  function automatic logic [1:0] exp_pin(input logic [7:0] x, input logic [31:0] v,
    input logic [4:0] g);
    if (x < 8'h20) return {1'b1, v[x[4:0]]};
    if (x < 8'h30) return {1'b1, g[x[2:0]]};
    return 2'b00;
  endfunction
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 0;
    global_reset_n <= 1;
    repeat (2) @(posedge ref_clk);
    rdr(OFS_ROUTING, rd, rs);
    `CHK(rd, 32'h0000_1000)
    wr(OFS_ROUTING, 32'hFFFF_FFFF, rs);
    `CHK(rs, RESP_OKAY)
    rdr(OFS_ROUTING, rd, rs);
    `CHK(rd, 32'h0FFF_FFFF)
    sys_rst <= 1;
    @(posedge ref_clk);
    sys_rst <= 0;
    repeat (2) @(posedge ref_clk);
    rdr(OFS_ROUTING, rd, rs);
    `CHK(rd, 32'h0FFF_FFFF)
    eeprom_load_data <= 32'hA5C3_9E71;
    eeprom_load_valid <= 1;
    @(posedge ref_clk);
    eeprom_load_valid <= 0;
    rdr(OFS_ROUTING, rd, rs);
    `CHK(rd, 32'h05C3_9E71)
    wr(OFS_GP_OUT, 32'h0000_001F, rs);
    global_reset_n <= 0;
    repeat (4) @(posedge ref_clk);
    global_reset_n <= 1;
    repeat (3) @(posedge ref_clk);
    rdr(OFS_ROUTING, rd, rs);
    `CHK(rd, 32'h0000_1000)
    rdr(OFS_GP_OUT, rd, rs);
    `CHK(rd[4:0], 5'h00)
    wr(4'hC, 32'h1234_5678, rs);
    `CHK(rs, RESP_SLVERR)
    rdr(4'hC, rd, rs);
    `CHK({rd, rs}, {32'h0, RESP_SLVERR})
    for (int i = 0; i < 40; i++) begin
      for (int t = 0; t < 7; t++) rt[4*t+:4] = (i < 16) ? i[3:0] : 4'($random(seed));
      wr(OFS_ROUTING, {4'h0, rt}, rs);
      gpo = 5'($random(seed));
      wr(OFS_GP_OUT, {27'h0, gpo}, rs);
      s <= {1'b0, 31'($random(seed))};
      ext_level <= 7'($random(seed));
      repeat (4) @(posedge ref_clk);
      gpi = 5'h00;
      for (int t = 0; t < 7; t++) begin
        e = TBL[t][8*rt[4*t+:4]+:8];
        if (e != 8'hEE) `CHK({term_oe[t], term_out[t]}, exp_pin(e, s, gpo))
        if (e[7:4] == 4'h3 && e[3:0] < 4'h5) gpi[e[2:0]] = ext_level[t];
      end
      `CHK(smartcard_debug_receive, (rt[23:20] == SC_RX_CODE) ? ext_level[5] : 1'b0)
      rdr(OFS_GP_IN, rd, rs);
      `CHK(rd[4:0], gpi)
    end
    give_verdict;
  end
endmodule
